// [rdg_pkg.sv]
// Purpose: Shared constants and types for the two-wire line driver gate.
// Assumes: 40 MHz module clock, 8N1 character framing on the line.
// Notes: Register addresses are word indices; byte address is four times each.
`default_nettype none

package rdg_pkg;

    // ------------------------------------------------------------
    // Clock and default line rate
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int BAUD_BPS_RST = 9600;
    // Clocks per bit at the reset rate, rounded down.
    localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_BPS_RST);

    // ------------------------------------------------------------
    // Register map (indices, then byte addresses)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_CTRL = 10'h000;
    localparam logic [9:0] IDX_BAUD = 10'h001;
    localparam logic [9:0] IDX_TXDATA = 10'h002;
    localparam logic [9:0] IDX_RXDATA = 10'h003;
    localparam logic [9:0] IDX_STATUS = 10'h004;
    localparam logic [9:0] IDX_ECHO = 10'h1C2;
    localparam logic [11:0] ADR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [11:0] ADR_BAUD = {IDX_BAUD, 2'b00};
    localparam logic [11:0] ADR_TXDATA = {IDX_TXDATA, 2'b00};
    localparam logic [11:0] ADR_RXDATA = {IDX_RXDATA, 2'b00};
    localparam logic [11:0] ADR_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [11:0] ADR_ECHO = {IDX_ECHO, 2'b00};

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_LINK_BIT = 0;
    localparam int ECHO_DISC_BIT = 0;
    localparam int RXD_VALID_BIT = 8;
    localparam int ST_DRV_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_FULL_BIT = 2;
    localparam int ST_EMPTY_BIT = 3;
    localparam int ST_OVR_BIT = 4;
    localparam int ST_FERR_BIT = 5;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] ECHO_RST = 16'h0000;

    // ------------------------------------------------------------
    // Framing and timing in bit times
    // ------------------------------------------------------------
    localparam int CHAR_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] FRAME_BITS = 5'h0A;
    localparam logic [4:0] PREAMBLE_BITS = 5'h14;
    localparam logic [4:0] HOLD_BITS = 5'h0A;

    // Transmit sequencer states.
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_MARK = 2'b01,
        TX_SHIFT = 2'b10,
        TX_HOLD = 2'b11
    } rdg_tx_st_t;

    // One received character with its valid flag.
    typedef struct packed {
        logic vld;
        logic [CHAR_W-1:0] data;
    } rdg_rx_word_t;

endpackage

`default_nettype wire

// [rdg_echo_ctrl.sv]
// Purpose: Line driver gating, echo discard and Avalon-MM registers.
// Assumes: One 40 MHz clock; line inputs are asynchronous to it.
// Notes: A 16-word FIFO holds characters queued for transmission.
//
// Summary of operation
// (RL1) Other stations drive only while transmitting.
// (RL2) Other stations float the line when idle.
// (RL3) Driver enable follows transmit activity automatically.
// (RL4) Linked mode holds driver one character longer.
// (RL5) Own transmission echoes onto own receiver.
// (RL6) Echo setting zero accepts echoed characters.
// (RL7) Echo setting one discards echoed characters.
// (RL8) Echo word at index 1C2, resets zero.
// (RL9) Echo setting frozen during a transmission.
// (RL10) Two idle mark characters before first data.
// (RL11) Unlinked: driver off within one bit.
// (RL12) Discard data and errors while driving, echo one.
//
// The Avalon-MM register port is this design's own decision.
`default_nettype none
// ----------------------------------------------------------------
// Synchronous FIFO with valid/ready on both sides
// ----------------------------------------------------------------
module rdg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];  // Storage words.
    logic [AW-1:0] wp_q;  // Write index.
    logic [AW-1:0] rp_q;  // Read index.
    logic [AW:0] cnt_q;  // Words held.
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];
    // Storage is written only on an accepted push.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
    // Indices wrap naturally since depth is a power of two.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop) rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
// ----------------------------------------------------------------
// Top: registers, transmit sequencer, receiver
// ----------------------------------------------------------------
module rdg_echo_ctrl
    import rdg_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [11:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic TX_LINE_POS,
    output logic TX_LINE_NEG,
    output logic TX_DRV_EN,
    input wire logic RX_LINE_POS,
    input wire logic RX_LINE_NEG
);
    // Merge bus bytes into a 16-bit register under byte enables.
    function automatic logic [15:0] be16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
        be16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_q;  // First reset stage.
    logic rst_n;  // Released reset used by all logic.
    // Assert at once, release after two clean edges.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end
    // ------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------
    logic [15:0] ctrl_q;  // Link mode control.
    logic [15:0] baud_q;  // Clocks per bit.
    logic [15:0] echo_q;  // Echo discard selection.
    logic rd_ack_q;  // Read data already staged.
    logic [31:0] rdata_q;  // Staged read data.
    rdg_rx_word_t rxw_q;  // Received character holder.
    logic ovr_q;  // Receive overrun, sticky.
    logic ferr_q;  // Framing error, sticky.
    logic fifo_in_rdy;
    logic fifo_vld;
    logic [CHAR_W-1:0] fifo_dat;
    logic fifo_pop;
    rdg_tx_st_t st_q;
    logic drv_q;
    wire sel_ctrl = (AVS_ADDRESS == ADR_CTRL);
    wire sel_baud = (AVS_ADDRESS == ADR_BAUD);
    wire sel_txd = (AVS_ADDRESS == ADR_TXDATA);
    wire sel_rxd = (AVS_ADDRESS == ADR_RXDATA);
    wire sel_stat = (AVS_ADDRESS == ADR_STATUS);
    wire sel_echo = (AVS_ADDRESS == ADR_ECHO);
    // A full FIFO stalls the bus: back-pressure reaches software.
    wire tx_stall = AVS_WRITE & sel_txd & ~fifo_in_rdy;
    assign AVS_WAITREQUEST = (AVS_READ & ~rd_ack_q) | tx_stall;
    wire wr_go = AVS_WRITE & ~tx_stall;
    wire rd_go = AVS_READ & rd_ack_q;
    wire txd_push = wr_go & sel_txd & AVS_BYTEENABLE[0];
    wire stat_clr = wr_go & sel_stat & AVS_BYTEENABLE[0];
    // Status word assembled from live block state.
    wire [31:0] stat_word = 32'({ferr_q, ovr_q, ~fifo_vld, ~fifo_in_rdy, st_q != TX_IDLE, drv_q});
    // Read data selection; unmapped addresses read as zero.
    wire [31:0] rsel = sel_ctrl ? {16'h0000, ctrl_q} : sel_baud ? {16'h0000, baud_q} : sel_rxd ? 32'(rxw_q) :
        sel_stat ? stat_word : sel_echo ? {16'h0000, echo_q} : 32'h0000_0000;
    assign AVS_READDATA = rdata_q;
    // Reads take two cycles: stage the data, then release the master.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rd_ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            rd_ack_q <= AVS_READ & ~rd_ack_q;
            if (AVS_READ & ~rd_ack_q) rdata_q <= rsel;
        end
    end
    // Writable registers; unmapped writes are dropped.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
            baud_q <= BAUD_DIV_RST;
            echo_q <= ECHO_RST;  // RL8
        end else if (wr_go) begin
            if (sel_ctrl) ctrl_q <= be16(ctrl_q, AVS_WRITEDATA, AVS_BYTEENABLE);
            if (sel_baud) baud_q <= be16(baud_q, AVS_WRITEDATA, AVS_BYTEENABLE);
            if (sel_echo) echo_q <= be16(echo_q, AVS_WRITEDATA, AVS_BYTEENABLE);  // RL8
        end
    end
    // ------------------------------------------------------------
    // Transmit queue
    // ------------------------------------------------------------
    rdg_fifo #(
        .WIDTH(CHAR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_txq (
        .clk(CLK),
        .rst_n(rst_n),
        .in_valid(txd_push),
        .in_ready(fifo_in_rdy),
        .in_data(AVS_WRITEDATA[CHAR_W-1:0]),
        .out_valid(fifo_vld),
        .out_ready(fifo_pop),
        .out_data(fifo_dat)
    );
    // ------------------------------------------------------------
    // Transmit sequencer
    // ------------------------------------------------------------
    rdg_tx_st_t st_d;
    logic [15:0] tdiv_q;  // Clocks left in this bit.
    logic [4:0] tbit_q;  // Bits left in this phase.
    logic [4:0] tbit_d;
    logic [9:0] tsh_q;  // Frame shifter, LSB on the line.
    logic echo_act_q;  // Echo setting latched per transmission.
    wire ttick = (tdiv_q == 16'h0000);
    wire tlast = (tbit_q == 5'h00);
    wire linked = ctrl_q[CTRL_LINK_BIT];
    // Next character is taken at a bit boundary when one is due.
    assign fifo_pop = ttick & ((st_q == TX_MARK & tlast) | (st_q == TX_SHIFT & tlast & fifo_vld) |
                               (st_q == TX_HOLD & fifo_vld));
    // Phase sequencing of the driver gate.
    always_comb begin
        st_d = st_q;
        tbit_d = tbit_q;
        case (st_q)
            TX_IDLE: begin
                if (fifo_vld) begin
                    st_d = TX_MARK;  // RL3
                    tbit_d = PREAMBLE_BITS - 5'h01;  // RL10
                end
            end
            TX_MARK: begin
                if (ttick) begin
                    if (tlast) begin
                        st_d = TX_SHIFT;
                        tbit_d = FRAME_BITS - 5'h01;
                    end else tbit_d = tbit_q - 5'h01;
                end
            end
            TX_SHIFT: begin
                if (ttick) begin
                    if (!tlast) tbit_d = tbit_q - 5'h01;
                    else if (fifo_vld) tbit_d = FRAME_BITS - 5'h01;
                    else if (linked) begin
                        st_d = TX_HOLD;  // RL4
                        tbit_d = HOLD_BITS - 5'h01;
                    end else st_d = TX_IDLE;  // RL11
                end
            end
            TX_HOLD: begin
                if (ttick) begin
                    if (fifo_vld) begin
                        st_d = TX_SHIFT;
                        tbit_d = FRAME_BITS - 5'h01;
                    end else if (tlast) st_d = TX_IDLE;  // RL4
                    else tbit_d = tbit_q - 5'h01;
                end
            end
            default: st_d = TX_IDLE;
        endcase
    end
    // Bit timer restarts whenever the line is idle.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= TX_IDLE;
            tbit_q <= 5'h00;
            tdiv_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            tbit_q <= tbit_d;
            tdiv_q <= (st_q == TX_IDLE || ttick) ? baud_q - 16'h0001 : tdiv_q - 16'h0001;
        end
    end
    // Shifter feeds ones outside frames so the line idles at mark.
    // The driver flop follows the next state, so it drops on the
    // same edge as the stop bit ends when unlinked: well inside one bit.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            tsh_q <= 10'h3FF;
            drv_q <= 1'b0;
            echo_act_q <= 1'b0;
        end else begin
            drv_q <= (st_d != TX_IDLE);  // RL3
            if (fifo_pop) tsh_q <= {1'b1, fifo_dat, 1'b0};
            else if (ttick) tsh_q <= {1'b1, tsh_q[9:1]};
            if (st_q == TX_IDLE && fifo_vld) begin
                echo_act_q <= echo_q[ECHO_DISC_BIT];  // RL9
            end
        end
    end
    assign TX_DRV_EN = drv_q;
    assign TX_LINE_POS = tsh_q[0];
    assign TX_LINE_NEG = ~tsh_q[0];
    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    logic [1:0] rp_q;  // Positive wire synchroniser.
    logic [1:0] rn_q;  // Negative wire synchroniser.
    logic rbusy_q;  // Character in progress.
    logic rdisc_q;  // Character is own echo to drop.
    logic [15:0] rdiv_q;  // Clocks to next sample.
    logic [3:0] rbit_q;  // Sample index, start bit is zero.
    logic [7:0] rsh_q;  // Data shifter.
    // Mark when the pair shows positive over negative.
    wire rbit = rp_q[1] & ~rn_q[1];
    wire rtick = (rdiv_q == 16'h0000);
    wire rstart = ~rbusy_q & ~rbit;
    wire rstop = rbusy_q & rtick & (rbit_q == 4'h9);
    // In two-wire use our own frames return here; drop them on request.
    wire rdisc_now = drv_q & echo_act_q;  // RL5 RL7 RL12
    // Only the second stage of each synchroniser is read.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rp_q <= 2'b11;
            rn_q <= 2'b00;
        end else begin
            rp_q <= {rp_q[0], RX_LINE_POS};
            rn_q <= {rn_q[0], RX_LINE_NEG};
        end
    end
    // Start edge waits half a bit, then samples at bit centres.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rbusy_q <= 1'b0;
            rdisc_q <= 1'b0;
            rdiv_q <= 16'h0000;
            rbit_q <= 4'h0;
            rsh_q <= 8'h00;
        end else if (rstart) begin
            rbusy_q <= 1'b1;
            rdisc_q <= rdisc_now;  // RL12
            rdiv_q <= {1'b0, baud_q[15:1]};
            rbit_q <= 4'h0;
        end else if (rbusy_q && rtick) begin
            rdiv_q <= baud_q - 16'h0001;
            rbit_q <= rbit_q + 4'h1;
            if (rbit_q == 4'h0 && rbit) rbusy_q <= 1'b0;  // False start.
            if (rbit_q != 4'h0 && rbit_q != 4'h9) rsh_q <= {rbit, rsh_q[7:1]};
            if (rstop) rbusy_q <= 1'b0;
        end else if (rbusy_q) begin
            rdiv_q <= rdiv_q - 16'h0001;
        end
    end
    // Delivery and error flags; a new event beats a clear.
    wire deliver = rstop & ~rdisc_q & rbit;  // RL6 RL7
    wire rxd_take = rd_go & sel_rxd;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rxw_q <= '0;
            ovr_q <= 1'b0;
            ferr_q <= 1'b0;
        end else begin
            if (deliver) begin
                rxw_q.vld <= 1'b1;
                rxw_q.data <= rsh_q;
            end else if (rxd_take) rxw_q.vld <= 1'b0;
            if (deliver && rxw_q.vld && !rxd_take) ovr_q <= 1'b1;
            else if (stat_clr && AVS_WRITEDATA[ST_OVR_BIT]) ovr_q <= 1'b0;
            if (rstop && !rdisc_q && !rbit) ferr_q <= 1'b1;  // RL12
            else if (stat_clr && AVS_WRITEDATA[ST_FERR_BIT]) ferr_q <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// [rdg_echo_ctrl_checker.sv]
// Purpose: Port-level assertions for the line driver gate block.
// Assumes: One clock domain; RST_B disables every check.
// Notes: Bound to each instance of the top module.
`default_nettype none

module rdg_echo_ctrl_checker
    import rdg_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [11:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic TX_LINE_POS,
    input wire logic TX_LINE_NEG,
    input wire logic TX_DRV_EN,
    input wire logic RX_LINE_POS,
    input wire logic RX_LINE_NEG
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    // High for any address that the register map decodes.
    wire logic mapped = (AVS_ADDRESS == ADR_CTRL) || (AVS_ADDRESS == ADR_BAUD) || (AVS_ADDRESS == ADR_TXDATA) ||
        (AVS_ADDRESS == ADR_RXDATA) || (AVS_ADDRESS == ADR_STATUS) || (AVS_ADDRESS == ADR_ECHO);

    pair_inverse_a: assert property (TX_LINE_NEG == !TX_LINE_POS)
        else $error("line pair not complementary");
    idle_mark_a: assert property (!TX_DRV_EN |-> TX_LINE_POS)
        else $error("space sent with driver off");
    pre_mark_a: assert property ($rose(TX_DRV_EN) |-> (TX_DRV_EN && TX_LINE_POS) [*8])
        else $error("no mark after driver on");
    start_late_a: assert property ($fell(TX_LINE_POS) |-> $past(TX_DRV_EN, 8))
        else $error("start bit too soon after driver on");
    end_mark_a: assert property ($fell(TX_DRV_EN) |-> $past(TX_LINE_POS))
        else $error("driver dropped during a space");
    read_wait_a: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("read wait not one cycle");
    write_accept_a: assert property (AVS_WRITE && AVS_ADDRESS != ADR_TXDATA |-> !AVS_WAITREQUEST)
        else $error("register write stalled");
    unmapped_zero_a: assert property (AVS_READ && !AVS_WAITREQUEST && !mapped |-> AVS_READDATA == 32'h0000_0000)
        else $error("unmapped read not zero");

    // Main scenarios: transmission start, end, and a stalled queue write.
    tx_start_c: cover property ($rose(TX_DRV_EN));
    tx_end_c: cover property ($fell(TX_DRV_EN));
    queue_stall_c: cover property (AVS_WRITE && AVS_WAITREQUEST);
endmodule

bind rdg_echo_ctrl rdg_echo_ctrl_checker i_rdg_echo_ctrl_checker (.CLK(CLK), .RST_B(RST_B),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .TX_LINE_POS(TX_LINE_POS), .TX_LINE_NEG(TX_LINE_NEG), .TX_DRV_EN(TX_DRV_EN),
    .RX_LINE_POS(RX_LINE_POS), .RX_LINE_NEG(RX_LINE_NEG));

`default_nettype wire

// [rdg_station_model.sv]
// Purpose: Far station on the shared two-wire line, with the loop-back of our own driver.
// Assumes: 8N1 frames of BIT_CYC clocks per bit.
// Notes: Bias resistors hold the line at mark when nobody drives.
`default_nettype none

module rdg_station_model #(
    parameter int BIT_CYC = 8
) (
    input wire logic clk,
    input wire logic drv_en,
    input wire logic tx_pos,
    output logic rx_pos,
    output logic rx_neg
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Line model
    // ------------------------------------------------------------
    logic st_drv = 1'b0; // Station driver enable.
    logic st_bit = 1'b1; // Station output level.

    // Our driver echoes onto our receiver; otherwise the station or the bias sets the level.
    assign rx_pos = drv_en ? tx_pos : (st_drv ? st_bit : 1'b1);
    assign rx_neg = !rx_pos;

    // Sends one character; the driver is on only for the frame itself.
    task automatic send_char(input logic [7:0] ch);
        logic [9:0] fr;
        fr = {1'b1, ch, 1'b0};
        @(posedge clk);
        st_drv <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            st_bit <= fr[i];
            repeat (BIT_CYC) @(posedge clk);
        end
        st_drv <= 1'b0;
    endtask
endmodule

`default_nettype wire

// [test_rdg_echo_ctrl.sv]
// Purpose: Self-checking bench for driver gating, echo discard and registers.
// Assumes: BAUD is written to 8 clocks per bit before any frame.
// Notes: Bus answers are taken at the rising edge that sees waitrequest low.
`default_nettype none

module test_rdg_echo_ctrl
    import rdg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals, design and far station
    // ------------------------------------------------------------
    logic CLK = 1'b0;
    logic RST_B = 1'b0;
    logic [11:0] AVS_ADDRESS = 12'h000;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
    logic [3:0] AVS_BYTEENABLE = 4'hF;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST, TX_LINE_POS, TX_LINE_NEG, TX_DRV_EN, RX_LINE_POS, RX_LINE_NEG;
    int err_count = 0;
    int check_count = 0;
    int last_wait; // Cycles of the latest bus transfer, answer cycle included.
    logic [31:0] q;
    int len;
    localparam int BIT_CYC = 8; // Clocks per bit used by every frame test.

    always #12.5 CLK = ~CLK;

    rdg_echo_ctrl i_rdg_echo_ctrl (.CLK(CLK), .RST_B(RST_B), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .TX_LINE_POS(TX_LINE_POS),
        .TX_LINE_NEG(TX_LINE_NEG), .TX_DRV_EN(TX_DRV_EN), .RX_LINE_POS(RX_LINE_POS), .RX_LINE_NEG(RX_LINE_NEG));
    rdg_station_model #(.BIT_CYC(BIT_CYC)) i_rdg_station_model (.clk(CLK), .drv_en(TX_DRV_EN), .tx_pos(TX_LINE_POS),
        .rx_pos(RX_LINE_POS), .rx_neg(RX_LINE_NEG));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus transfer, held until waitrequest is seen low; a hang counts as a mismatch.
    task automatic av(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd);
        logic w;
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        w = 1'b1;
        last_wait = 0;
        while (w && last_wait < 2000) begin
            @(posedge CLK);
            w = AVS_WAITREQUEST;
            rd = AVS_READDATA;
            last_wait++;
        end
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        if (w !== 1'b0) begin
            err_count++;
            $display("[ERR] bus answer expected 0 seen %b", w);
            close_out();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        av(1'b1, a, d, dummy);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        av(1'b0, a, 32'h0000_0000, v);
    endtask

    // Measures how many cycles the driver enable stays high in the next transmission.
    task automatic drv_window(output int n);
        int t;
        t = 0;
        do begin
            @(negedge CLK);
            t++;
        end while (TX_DRV_EN !== 1'b1 && t < 3000);
        n = 0;
        while (TX_DRV_EN === 1'b1 && n < 5000) begin
            n++;
            @(negedge CLK);
        end
        if (t >= 3000 || n >= 5000) begin
            err_count++;
            $display("[ERR] driver window expected bounded seen %0d", n);
            close_out();
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd(ADR_ECHO, q); chk("echo reset", 32'h0000_0000, q);
        rd(ADR_BAUD, q); chk("baud reset", {16'h0000, BAUD_DIV_RST}, q);
        rd(ADR_STATUS, q); chk("status reset", 32'h0000_0008, q);
        wr(12'h0FC, 32'h0000_FFFF);
        rd(12'h0FC, q); chk("unmapped", 32'h0000_0000, q);
        wr(ADR_ECHO, 32'h0000_0001);
        rd(ADR_ECHO, q); chk("echo rw", 32'h0000_0001, q);
        wr(ADR_ECHO, 32'h0000_0000);
        $display("test regs done");
    endtask

    task automatic t_unlinked_echo();
        wr(ADR_BAUD, BIT_CYC);
        wr(ADR_TXDATA, 32'h0000_00A5);
        drv_window(len);
        chk("unlinked window", BIT_CYC * (PREAMBLE_BITS + FRAME_BITS), len);
        rd(ADR_RXDATA, q); chk("echo kept", 32'h0000_01A5, q);
        $display("test unlinked done");
    endtask

    // Linked hold with discard on; clearing the setting during the preamble must not take effect.
    task automatic t_linked_discard();
        wr(ADR_ECHO, 32'h0000_0001);
        wr(ADR_CTRL, 32'h0000_0001);
        wr(ADR_TXDATA, 32'h0000_003C);
        fork
            drv_window(len);
            begin
                repeat (60) @(posedge CLK);
                wr(ADR_ECHO, 32'h0000_0000);
            end
        join
        chk("linked window", BIT_CYC * (PREAMBLE_BITS + FRAME_BITS + HOLD_BITS), len);
        rd(ADR_RXDATA, q); chk("echo dropped", 32'h0000_0000, {31'h0, q[8]});
        rd(ADR_STATUS, q); chk("echo errors", 32'h0000_0000, {30'h0, q[5:4]});
        wr(ADR_CTRL, 32'h0000_0000);
        $display("test linked done");
    endtask

    task automatic t_station();
        wr(ADR_ECHO, 32'h0000_0001);
        i_rdg_station_model.send_char(8'h5A);
        repeat (4) @(posedge CLK);
        rd(ADR_RXDATA, q); chk("foreign char", 32'h0000_015A, q);
        wr(ADR_ECHO, 32'h0000_0000);
        $display("test station done");
    endtask

    // Overfill the queue, let it drain; accepted echoes overrun the unread receive word.
    task automatic t_fifo();
        int stalls;
        stalls = 0;
        for (int i = 0; i < 18; i++) begin
            wr(ADR_TXDATA, 32'h0000_0040 + i);
            if (last_wait > 1) stalls++;
        end
        chk("queue stall", 32'd1, {31'h0, stalls > 0});
        drv_window(len);
        rd(ADR_STATUS, q); chk("drained", 32'h0000_0018, q);
        wr(ADR_STATUS, 32'h0000_0030);
        rd(ADR_STATUS, q); chk("cleared", 32'h0000_0008, q);
        $display("test fifo done");
    endtask

    initial begin
        repeat (8) @(posedge CLK);
        RST_B <= 1'b1;
        repeat (3) @(posedge CLK);
        t_regs();
        t_unlinked_echo();
        t_linked_discard();
        t_station();
        t_fifo();
        close_out();
    end
endmodule

`default_nettype wire
